// [inc/video_switch_regs.svh]
/*
  register map, field positions, reset values and timing counts of the
  video switch configuration bank. assumes an 8-bit register address space.
*/
`ifndef VIDEO_SWITCH_REGS_SVH
`define VIDEO_SWITCH_REGS_SVH

// ==========================================================
// serial bus address
`define DEV_ADDR_UPPER 6'h24

// ==========================================================
// register offsets
`define ADDR_FAST_MODE 8'h00
`define ADDR_SIDE_MODE 8'h01
`define ADDR_RX_SETTINGS 8'h10
`define ADDR_TERM_SELECT 8'h11
`define ADDR_EQ_LEVEL 8'h14
`define ADDR_TX_SETTINGS 8'h20
`define ADDR_POLARITY 8'h80
`define ADDR_MAP_A 8'h81
`define ADDR_MAP_B 8'h82
`define REG_COUNT 9

// ==========================================================
// reset values
`define RST_FAST_MODE 8'h40
`define RST_SIDE_MODE 8'hc0
`define RST_RX_SETTINGS 8'h01
`define RST_TERM_SELECT 8'h00
`define RST_EQ_LEVEL 8'hff
`define RST_TX_SETTINGS 8'h03
`define RST_POLARITY 8'h00
`define RST_MAP_A 8'he4
`define RST_MAP_B 8'he4

// ==========================================================
// implemented bits
`define MASK_FAST_MODE 8'h41
`define MASK_SIDE_MODE 8'hc1
`define MASK_RX_SETTINGS 8'h01
`define MASK_FULL 8'hff
`define MASK_TX_SETTINGS 8'h0f

// ==========================================================
// field positions
`define BIT_FAST_ENABLE 6
`define BIT_FAST_SEL 0
`define BIT_SIDE_LOCK 7
`define BIT_SIDE_ENABLE 6
`define BIT_SIDE_SEL 0

// ==========================================================
// timing
`define CLOCK_KHZ 50000
`define HOT_PLUG_MS 100

`endif

// [inc/video_switch_pkg.sv]
/*
  types of the video switch configuration bank.
  holds its own literal state and phase encodings and needs no constants header.
*/
`default_nettype none
package video_switch_pkg;

  // gray codes along idle, receive, ack, transmit, master ack
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX = 3'h1,
    S_ACK = 3'h3,
    S_TX = 3'h2,
    S_MACK = 3'h6
  } bus_state_type;

  typedef enum logic [1:0] {
    PH_DEV = 2'h0,
    PH_REG = 2'h1,
    PH_DATA = 2'h3
  } byte_phase_type;

  typedef struct packed {
    logic fastPathEnable;
    logic fastPathSource;
    logic sideChannelEnable;
    logic sideChannelSource;
    logic terminationModeSel;
    logic [7:0] inputTerminationBits;
    logic [7:0] inputEqualizerBits;
    logic [1:0] outputEmphasisLevel;
    logic outputTerminationOn;
    logic outputCurrentLevel;
    logic [3:0] srcAPolarity;
    logic [3:0] srcBPolarity;
    logic [3:0][2:0] outChanSel;
  } switch_cfg_type;

endpackage : video_switch_pkg
`default_nettype wire

// [rtl/video_switch_config_regs.sv]
/*
  serial-bus configuration bank of a two-input video link switch, with the
  derived switch controls and the hot-plug pulse. assumes scl and sda are
  synchronous to clock and far slower than it, and open-drain pads outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "video_switch_regs.svh"

module video_switch_config_regs #(
  parameter int HOT_PLUG_CYCLES = `HOT_PLUG_MS * `CLOCK_KHZ + 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic addrSel,
  output logic hotPlugOut,
  output logic hotPlugOeN,
  output video_switch_pkg::switch_cfg_type cfg
);
  import video_switch_pkg::*;

  localparam logic [7:0] REG_ADDR [`REG_COUNT] = '{`ADDR_FAST_MODE, `ADDR_SIDE_MODE,
    `ADDR_RX_SETTINGS, `ADDR_TERM_SELECT, `ADDR_EQ_LEVEL, `ADDR_TX_SETTINGS,
    `ADDR_POLARITY, `ADDR_MAP_A, `ADDR_MAP_B};
  localparam logic [7:0] REG_RST [`REG_COUNT] = '{`RST_FAST_MODE, `RST_SIDE_MODE,
    `RST_RX_SETTINGS, `RST_TERM_SELECT, `RST_EQ_LEVEL, `RST_TX_SETTINGS,
    `RST_POLARITY, `RST_MAP_A, `RST_MAP_B};
  localparam logic [7:0] REG_MASK [`REG_COUNT] = '{`MASK_FAST_MODE, `MASK_SIDE_MODE,
    `MASK_RX_SETTINGS, `MASK_FULL, `MASK_FULL, `MASK_TX_SETTINGS,
    `MASK_FULL, `MASK_FULL, `MASK_FULL};
  localparam logic [22:0] HOT_PLUG_LOAD = 23'(HOT_PLUG_CYCLES);

  logic sclQ_ff, sdaQ_ff, sclPrev_ff, sdaPrev_ff;
  logic startSeen, stopSeen, sclRise, sclFall;
  bus_state_type state_ff;
  byte_phase_type phase_ff;
  logic [2:0] bitCnt_ff;
  logic byteFull_ff;
  logic [7:0] shift_ff;
  logic [7:0] txShift_ff;
  logic readMode_ff;
  logic masterAck_ff;
  logic [7:0] regAddr_ff;
  logic wrStb_ff;
  logic [7:0] wrData_ff;
  logic [7:0] regFile_ff [`REG_COUNT];
  logic [7:0] rdData;
  logic addrMatch;
  logic fastSel, sideSel, switchEvent;
  logic [22:0] hotPlugCnt_ff;

  // ==========================================================
  // pin sampling and bus conditions
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclQ_ff <= 1'b1;
      sdaQ_ff <= 1'b1;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else if (ce) begin
      sclQ_ff <= sclIn;
      sdaQ_ff <= sdaIn;
      sclPrev_ff <= sclQ_ff;
      sdaPrev_ff <= sdaQ_ff;
    end
  end

  // start and stop only count while scl stays high over both samples
  assign startSeen = sclQ_ff && sclPrev_ff && sdaPrev_ff && !sdaQ_ff;
  assign stopSeen = sclQ_ff && sclPrev_ff && !sdaPrev_ff && sdaQ_ff;
  assign sclRise = sclQ_ff && !sclPrev_ff;
  assign sclFall = !sclQ_ff && sclPrev_ff;
  assign addrMatch = (shift_ff[7:1] == {`DEV_ADDR_UPPER, addrSel});

  // ==========================================================
  // serial slave state machine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      phase_ff <= PH_DEV;
      bitCnt_ff <= 3'h0;
      byteFull_ff <= 1'b0;
      shift_ff <= 8'h00;
      txShift_ff <= 8'h00;
      readMode_ff <= 1'b0;
      masterAck_ff <= 1'b0;
      regAddr_ff <= 8'h00;
      wrStb_ff <= 1'b0;
      wrData_ff <= 8'h00;
      sdaOeN <= 1'b1;
      sdaOut <= 1'b0;
    end else if (ce) begin
      wrStb_ff <= 1'b0;
      if (startSeen) begin
        state_ff <= S_RX;
        phase_ff <= PH_DEV;
        bitCnt_ff <= 3'h0;
        byteFull_ff <= 1'b0;
        sdaOeN <= 1'b1;
      end else if (stopSeen) begin
        state_ff <= S_IDLE;
        sdaOeN <= 1'b1;
      end else begin
        case (state_ff)
          S_RX: begin
            if (sclRise) begin
              shift_ff <= {shift_ff[6:0], sdaQ_ff};
              bitCnt_ff <= bitCnt_ff + 3'h1;
              byteFull_ff <= (bitCnt_ff == 3'h7);
            end else if (sclFall && byteFull_ff) begin
              byteFull_ff <= 1'b0;
              state_ff <= S_ACK;
              sdaOeN <= 1'b0;
              case (phase_ff)
                PH_DEV: begin
                  readMode_ff <= shift_ff[0];
                  // a foreign address is never acknowledged
                  if (!addrMatch) begin
                    state_ff <= S_IDLE;
                    sdaOeN <= 1'b1;
                  end
                end
                PH_REG: regAddr_ff <= shift_ff;
                default: begin
                  wrStb_ff <= 1'b1;
                  wrData_ff <= shift_ff;
                end
              endcase
            end
          end
          S_ACK: begin
            if (sclFall) begin
              bitCnt_ff <= 3'h0;
              if (phase_ff == PH_DEV && readMode_ff) begin
                state_ff <= S_TX;
                txShift_ff <= rdData;
                sdaOeN <= rdData[7];
              end else begin
                state_ff <= S_RX;
                sdaOeN <= 1'b1;
                phase_ff <= (phase_ff == PH_DEV) ? PH_REG : PH_DATA;
              end
            end
          end
          S_TX: begin
            if (sclFall) begin
              bitCnt_ff <= bitCnt_ff + 3'h1;
              if (bitCnt_ff == 3'h7) begin
                state_ff <= S_MACK;
                masterAck_ff <= 1'b0;
                sdaOeN <= 1'b1;
              end else begin
                txShift_ff <= {txShift_ff[6:0], 1'b0};
                sdaOeN <= txShift_ff[6];
              end
            end
          end
          S_MACK: begin
            if (sclRise) begin
              masterAck_ff <= !sdaQ_ff;
              if (sdaQ_ff) begin
                state_ff <= S_IDLE;
              end
            end else if (sclFall && masterAck_ff) begin
              // no auto-increment: repeated reads return the same register
              state_ff <= S_TX;
              bitCnt_ff <= 3'h0;
              txShift_ff <= rdData;
              sdaOeN <= rdData[7];
            end
          end
          default: begin
            sdaOeN <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // register storage
  generate
    for (genvar i = 0; i < `REG_COUNT; i++) begin : gen_reg
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          regFile_ff[i] <= REG_RST[i];
        end else if (ce && wrStb_ff && regAddr_ff == REG_ADDR[i]) begin
          regFile_ff[i] <= wrData_ff & REG_MASK[i];
        end
      end
    end
  endgenerate

  // unmapped addresses still acknowledge, read zero and drop writes
  always_comb begin
    rdData = 8'h00;
    for (int j = 0; j < `REG_COUNT; j++) begin
      if (regAddr_ff == REG_ADDR[j]) begin
        rdData = regFile_ff[j];
      end
    end
  end

  // ==========================================================
  // switch controls
  assign fastSel = regFile_ff[0][`BIT_FAST_SEL];
  // lock slaves the side channel to the fast path select
  assign sideSel = regFile_ff[1][`BIT_SIDE_LOCK] ? fastSel :
    regFile_ff[1][`BIT_SIDE_SEL];
  assign switchEvent = (cfg.fastPathSource != fastSel) || (cfg.sideChannelSource != sideSel);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg.fastPathEnable <= 1'(`RST_FAST_MODE >> `BIT_FAST_ENABLE);
      cfg.fastPathSource <= 1'b0;
      cfg.sideChannelEnable <= 1'b1;
      cfg.sideChannelSource <= 1'b0;
    end else if (ce) begin
      cfg.fastPathEnable <= regFile_ff[0][`BIT_FAST_ENABLE];
      cfg.fastPathSource <= fastSel;
      cfg.sideChannelEnable <= regFile_ff[1][`BIT_SIDE_ENABLE];
      cfg.sideChannelSource <= sideSel;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg.terminationModeSel <= 1'b1;
      cfg.inputTerminationBits <= `RST_TERM_SELECT;
      cfg.inputEqualizerBits <= `RST_EQ_LEVEL;
      cfg.outputEmphasisLevel <= 2'h0;
      cfg.outputTerminationOn <= 1'b1;
      cfg.outputCurrentLevel <= 1'b1;
      cfg.srcAPolarity <= 4'h0;
      cfg.srcBPolarity <= 4'h0;
    end else if (ce) begin
      cfg.terminationModeSel <= regFile_ff[2][0];
      cfg.inputTerminationBits <= regFile_ff[3];
      cfg.inputEqualizerBits <= regFile_ff[4];
      cfg.outputEmphasisLevel <= regFile_ff[5][3:2];
      cfg.outputTerminationOn <= regFile_ff[5][1];
      cfg.outputCurrentLevel <= regFile_ff[5][0];
      cfg.srcAPolarity <= regFile_ff[6][3:0];
      cfg.srcBPolarity <= regFile_ff[6][7:4];
    end
  end

  // per output: source bit above the two-bit input channel index
  generate
    for (genvar k = 0; k < 4; k++) begin : gen_out
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          cfg.outChanSel[k] <= {1'b0, 2'(k)};
        end else if (ce) begin
          cfg.outChanSel[k] <= fastSel ? {1'b1, regFile_ff[8][2*k +: 2]} :
            {1'b0, regFile_ff[7][2*k +: 2]};
        end
      end
    end
  endgenerate

  // ==========================================================
  // hot-plug pulse; a switch during the pulse restarts it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hotPlugCnt_ff <= 23'h0;
      hotPlugOeN <= 1'b1;
      hotPlugOut <= 1'b0;
    end else if (ce) begin
      if (switchEvent) begin
        hotPlugCnt_ff <= HOT_PLUG_LOAD;
        hotPlugOeN <= 1'b0;
      end else if (hotPlugCnt_ff != 23'h0) begin
        hotPlugCnt_ff <= hotPlugCnt_ff - 23'h1;
        hotPlugOeN <= (hotPlugCnt_ff == 23'h1);
      end
    end
  end

  // ==========================================================
  // checks
  dev_ack_a: assert property (@(posedge clock) disable iff (rst)
    (state_ff == S_ACK && phase_ff == PH_DEV) |-> addrMatch && !sdaOeN)
    else $error("device address acknowledged without match");
  write_mask_a: assert property (@(posedge clock) disable iff (rst)
    (ce && wrStb_ff && regAddr_ff == `ADDR_FAST_MODE)
    |=> regFile_ff[0] == ($past(wrData_ff) & `MASK_FAST_MODE))
    else $error("fast-path mode write not stored");
  reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
    (regFile_ff[1] & ~`MASK_SIDE_MODE) == 8'h00 && (regFile_ff[5] & 8'hf0) == 8'h00)
    else $error("undefined register bits set");
  standby_a: assert property (@(posedge clock) disable iff (rst)
    (ce && !regFile_ff[0][`BIT_FAST_ENABLE]) |=> !cfg.fastPathEnable)
    else $error("fast path not in standby");
  lock_follow_a: assert property (@(posedge clock) disable iff (rst)
    (ce && regFile_ff[1][`BIT_SIDE_LOCK]) |=> cfg.sideChannelSource == $past(fastSel))
    else $error("locked side channel not following");
  unlock_own_a: assert property (@(posedge clock) disable iff (rst)
    (ce && !regFile_ff[1][`BIT_SIDE_LOCK])
    |=> cfg.sideChannelSource == $past(regFile_ff[1][`BIT_SIDE_SEL]))
    else $error("unlocked side channel wrong source");
  side_enable_a: assert property (@(posedge clock) disable iff (rst)
    ce |=> cfg.sideChannelEnable == $past(regFile_ff[1][`BIT_SIDE_ENABLE]))
    else $error("side channel enable mismatch");
  hot_plug_a: assert property (@(posedge clock) disable iff (rst)
    (ce && switchEvent) |=> !hotPlugOeN && hotPlugCnt_ff == HOT_PLUG_LOAD)
    else $error("hot-plug pulse not started");
  read_bit_a: assert property (@(posedge clock) disable iff (rst)
    (state_ff == S_TX && $past(state_ff) == S_TX) |-> sdaOeN == txShift_ff[7])
    else $error("read bit not driven");
  source_route_a: assert property (@(posedge clock) disable iff (rst)
    ce |=> cfg.fastPathSource == $past(regFile_ff[0][`BIT_FAST_SEL]))
    else $error("fast-path source not routed");
  pulse_end_a: assert property (@(posedge clock) disable iff (rst)
    (ce && !switchEvent && hotPlugCnt_ff == 23'h1) |=> hotPlugOeN && hotPlugCnt_ff == 23'h0)
    else $error("hot-plug line not released");
  write_cov_c: cover property (@(posedge clock) wrStb_ff && regAddr_ff == `ADDR_SIDE_MODE);
  read_cov_c: cover property (@(posedge clock) state_ff == S_MACK && masterAck_ff);
  pulse_cov_c: cover property (@(posedge clock) $rose(hotPlugOeN));
  locked_switch_c: cover property (@(posedge clock)
    switchEvent && regFile_ff[1][`BIT_SIDE_LOCK]);

endmodule : video_switch_config_regs
`default_nettype wire

// [tb/serial_host_model.sv]
/*
  host side of the two-wire serial bus: a master that writes and reads
  one configuration register per transfer.
  assumes a pull-up on sda, resolved by the bench, and a free-running clock.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
  input wire logic clock,
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaLowOut
);
  // ==========================================================
  // bus phases
  initial begin
    sclOut = 1'b1;
    sdaLowOut = 1'b0;
  end

  // six clocks a phase, above the four the slave needs
  task automatic gap();
    repeat (6) @(posedge clock);
  endtask : gap

  // data moves only while scl is low
  task automatic xbit(input logic b, output logic r);
    sdaLowOut <= ~b;
    gap();
    sclOut <= 1'b1;
    gap();
    r = sdaLine;
    sclOut <= 1'b0;
    gap();
  endtask : xbit

  // sda falls while scl high, also as repeated start
  task automatic start();
    sdaLowOut <= 1'b0;
    gap();
    sclOut <= 1'b1;
    gap();
    sdaLowOut <= 1'b1;
    gap();
    sclOut <= 1'b0;
    gap();
  endtask : start

  task automatic stop();
    sdaLowOut <= 1'b1;
    gap();
    sclOut <= 1'b1;
    gap();
    sdaLowOut <= 1'b0;
    gap();
  endtask : stop

  // msb first, ninth bit is the acknowledge
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r,
                       output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(last, ack);
  endtask : xbyte

  // ==========================================================
  // transfers
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                           output logic ok);
    logic [7:0] junk;
    logic a0;
    logic a1;
    logic a2;
    start();
    xbyte({dev, 1'b0}, 1'b1, junk, a0);
    xbyte(ra, 1'b1, junk, a1);
    xbyte(d, 1'b1, junk, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask : write_reg

  // single byte, ended by a no-acknowledge
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d,
                          output logic ok);
    logic [7:0] junk;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start();
    xbyte({dev, 1'b0}, 1'b1, junk, a0);
    xbyte(ra, 1'b1, junk, a1);
    start();
    xbyte({dev, 1'b1}, 1'b1, junk, a2);
    xbyte(8'hff, 1'b1, d, a3);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask : read_reg

  // two bytes with an acknowledge between: the slave repeats the register
  task automatic read_reg2(input logic [6:0] dev, input logic [7:0] ra,
                           output logic [7:0] d0, output logic [7:0] d1, output logic ok);
    logic [7:0] junk;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    logic a4;
    start();
    xbyte({dev, 1'b0}, 1'b1, junk, a0);
    xbyte(ra, 1'b1, junk, a1);
    start();
    xbyte({dev, 1'b1}, 1'b1, junk, a2);
    xbyte(8'hff, 1'b0, d0, a3);
    xbyte(8'hff, 1'b1, d1, a4);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask : read_reg2
endmodule : serial_host_model

`default_nettype wire

// [tb/testbench.sv]
/*
  register-level bench of the video switch configuration bank.
  assumes the host model for bus traffic and a short hot-plug count.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import video_switch_pkg::*;
  localparam int PULSE = 20;
  localparam int LIMIT = 80000;
  logic clock;
  logic rst;
  logic sclIn;
  logic sdaIn;
  logic sdaOut;
  logic sdaOeN;
  logic addrSel;
  logic hotPlugOut;
  logic hotPlugOeN;
  logic sdaLow;
  switch_cfg_type cfg;
  int bad_count;
  int tests_run;
  int cycles;
  int lowRun;
  int lastPulse;
  int pulses;
  int held;
  logic [6:0] dev;
  logic [7:0] rd;
  logic [7:0] rd2;
  logic ce;
  logic ok;
  logic [7:0] addrs [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h14, 8'h20, 8'h80, 8'h81, 8'h82};
  logic [7:0] dflt [9] = '{8'h40, 8'hc0, 8'h01, 8'h00, 8'hff, 8'h03, 8'h00, 8'he4, 8'he4};
  logic [7:0] wval [9] = '{8'hff, 8'hff, 8'hff, 8'h3c, 8'h5a, 8'hff, 8'ha5, 8'h1b, 8'h1b};
  logic [7:0] rval [9] = '{8'h41, 8'hc1, 8'h01, 8'h3c, 8'h5a, 8'h0f, 8'ha5, 8'h1b, 8'h1b};

  // released sda floats high through the pull-up
  assign sdaIn = ~sdaLow & (sdaOeN | sdaOut);

  video_switch_config_regs #(.HOT_PLUG_CYCLES(PULSE)) video_switch_config_regs_i (
    .clock(clock), .rst(rst), .ce(ce), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .addrSel(addrSel), .hotPlugOut(hotPlugOut), .hotPlugOeN(hotPlugOeN),
    .cfg(cfg)
  );
  serial_host_model serial_host_model_i (
    .clock(clock), .sdaLine(sdaIn), .sclOut(sclIn), .sdaLowOut(sdaLow)
  );

  // ==========================================================
  // clock, watchdog, pin monitor
  initial clock = 1'b0;
  always #10 clock = ~clock;

  always @(posedge clock) begin
    if (hotPlugOeN === 1'b0) begin
      lowRun++;
    end else if (lowRun != 0) begin
      lastPulse = lowRun;
      pulses++;
      lowRun = 0;
    end
    // open-drain pins may only ever pull low
    if (hotPlugOut !== 1'b0 || (sdaOeN === 1'b0 && sdaOut !== 1'b0)) begin
      bad_count++;
      $display("[FAIL] pin drive expected 0 seen %b %b", hotPlugOut, sdaOut);
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("[FAIL] watchdog expected done seen %0d cycles", cycles);
      wrap_up();
    end
  end

  // ==========================================================
  // tasks
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check16

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    serial_host_model_i.write_reg(dev, ra, d, ok);
    check16("write ack", 16'h1, 16'(ok));
  endtask : wr

  task automatic rdchk(input logic [7:0] ra, input logic [7:0] exp);
    serial_host_model_i.read_reg(dev, ra, rd, ok);
    check16("read ack", 16'h1, 16'(ok));
    check16($sformatf("reg %h", ra), 16'(exp), 16'(rd));
  endtask : rdchk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    addrSel = 1'b0;
    dev = {6'h24, 1'b0};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check16("map out", 16'h688, 16'(cfg.outChanSel));
    check16("fast en", 16'h1, 16'(cfg.fastPathEnable));
    for (int i = 0; i < 9; i++) begin
      rdchk(addrs[i], dflt[i]);
    end
    rdchk(8'h05, 8'h00);
    wr(8'h05, 8'h77);
    rdchk(8'h05, 8'h00);
    // locked by default: side source follows the fast-path select
    wr(8'h82, 8'h1b);
    wr(8'h00, 8'hff);
    check16("fast src", 16'h1, 16'(cfg.fastPathSource));
    check16("side src", 16'h1, 16'(cfg.sideChannelSource));
    check16("map out", 16'h977, 16'(cfg.outChanSel));
    check16("pulses", 16'h1, 16'(pulses));
    check16("pulse len", 16'(PULSE), 16'(lastPulse));
    rdchk(8'h00, 8'h41);
    wr(8'h01, 8'h40);
    check16("side src", 16'h0, 16'(cfg.sideChannelSource));
    check16("pulses", 16'h2, 16'(pulses));
    wr(8'h00, 8'h40);
    check16("side src", 16'h0, 16'(cfg.sideChannelSource));
    check16("map out", 16'h688, 16'(cfg.outChanSel));
    wr(8'h01, 8'h01);
    check16("side en", 16'h0, 16'(cfg.sideChannelEnable));
    check16("side src", 16'h1, 16'(cfg.sideChannelSource));
    wr(8'h00, 8'h00);
    check16("fast en", 16'h0, 16'(cfg.fastPathEnable));
    wr(8'h01, 8'h81);
    check16("side src", 16'h0, 16'(cfg.sideChannelSource));
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], wval[i]);
      rdchk(addrs[i], rval[i]);
    end
    check16("term bits", 16'h3c, 16'(cfg.inputTerminationBits));
    check16("eq bits", 16'h5a, 16'(cfg.inputEqualizerBits));
    check16("term mode", 16'h1, 16'(cfg.terminationModeSel));
    check16("tx emph", 16'h3, 16'(cfg.outputEmphasisLevel));
    check16("tx term cur", 16'h3, 16'({cfg.outputTerminationOn, cfg.outputCurrentLevel}));
    check16("polarity", 16'h5a, 16'({cfg.srcAPolarity, cfg.srcBPolarity}));
    check16("side src", 16'h1, 16'(cfg.sideChannelSource));
    // address low bit taken from the select pin
    addrSel <= 1'b1;
    serial_host_model_i.write_reg({6'h24, 1'b0}, 8'h11, 8'h00, ok);
    check16("stale addr", 16'h0, 16'(ok));
    serial_host_model_i.write_reg({6'h25, 1'b1}, 8'h11, 8'h00, ok);
    check16("upper bits", 16'h0, 16'(ok));
    dev = {6'h24, 1'b1};
    // frozen clock enable: no acknowledge, nothing stored
    ce <= 1'b0;
    serial_host_model_i.write_reg(dev, 8'h11, 8'h00, ok);
    check16("frozen ack", 16'h0, 16'(ok));
    ce <= 1'b1;
    rdchk(8'h11, 8'h3c);
    // master acknowledge repeats the same register
    serial_host_model_i.read_reg2(dev, 8'h11, rd, rd2, ok);
    check16("reread ack", 16'h1, 16'(ok));
    check16("reread", 16'h3c3c, {rd, rd2});
    // reset in mid-run restores every default, no hot-plug pulse
    held = pulses;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      rdchk(addrs[i], dflt[i]);
    end
    check16("pulses", 16'(held), 16'(pulses));
    check16("map out", 16'h688, 16'(cfg.outChanSel));
    check16("fast src", 16'h0, 16'(cfg.fastPathSource));
    check16("tx emph", 16'h0, 16'(cfg.outputEmphasisLevel));
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
